/* src/sspi_master.sv */
// Serial register port master: drives select, serial clock and data into the sensor port.
// Assumes a 25 MHz i_clk, synchronous active-high reset, miso arriving from off chip.
//
// Functional notes
// - Every access starts by pulling select low; slave answers only while selected.
// - Each access carries a 9-bit address and a 16-bit data word.
// - Wait one serial period after select, then send address MSB first.
// - Select low to first rising serial clock edge is at least one period.
// - Master changes its outgoing data on falling serial clock edges.
// - Bit after the address is direction: one writes, zero reads.
// - For a write, sixteen data bits follow MSB first on mosi.
// - Master samples miso on the falling serial clock edge during a read.
// - After the last bit wait one serial period, then raise select.
// - Serial clock stays at or below 10 MHz.
// - Between accesses deselect and idle at least two serial periods.
module sspi_master (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_reset,
   // User request
   input  wire logic                  i_req_valid,
   input  wire sspi_pkg::sspi_req_t   i_req,
   output logic                       o_req_ready,
   // User answer
   output sspi_pkg::sspi_rsp_t        o_rsp,
   // Serial pins
   output logic                       o_sck,
   output logic                       o_ss_n,
   output logic                       o_mosi,
   input  wire logic                  i_miso
);
   timeunit 1ns;
   timeprecision 100ps;

   // Sequencer phases: select lead-in, bit shifting, lead-out before deselect, and the
   // enforced idle gap. A request that arrives in any phase but idle simply waits, so a
   // user that keeps valid high never loses an access and never shortens the gap.
   typedef enum logic [2:0] {S_IDLE, S_LEAD, S_SHIFT, S_TAIL, S_GAP} sspi_state_t;

   // Phase lengths in system cycles, as the last count value of each phase. At 25 MHz
   // the serial half period is two cycles, so one serial period is four cycles: lead
   // and tail last four cycles each and the gap eight. The counter is wider than any
   // of them needs, which leaves room for a slower serial clock in the package.
   localparam int unsigned CNT_W = 8;
   localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(sspi_pkg::SCK_HALF_CYC - 1);
   localparam logic [CNT_W-1:0] LEAD_LAST =
      CNT_W'(sspi_pkg::LEAD_PERIODS * sspi_pkg::SCK_PERIOD_CYC - 1);
   localparam logic [CNT_W-1:0] TAIL_LAST =
      CNT_W'(sspi_pkg::TAIL_PERIODS * sspi_pkg::SCK_PERIOD_CYC - 1);
   localparam logic [CNT_W-1:0] GAP_LAST  =
      CNT_W'(sspi_pkg::GAP_PERIODS * sspi_pkg::SCK_PERIOD_CYC - 1);
   localparam logic [4:0] LAST_BIT = 5'(sspi_pkg::FRAME_BITS - 1);
   localparam int unsigned SR_W = sspi_pkg::FRAME_BITS;

   sspi_state_t              state;
   logic [CNT_W-1:0]         cnt;
   logic [4:0]               bit_idx;
   logic [SR_W-1:0]          shreg;
   logic                     is_write;
   logic [sspi_pkg::DATA_W-1:0] rd_shift;
   logic                     miso_s;
   logic                     half_done;
   logic                     fall_rd;
   logic [1:0]               cap_pipe;

   // Miso comes from off chip: synchronise before use. The two stages delay the pin by
   // two system cycles; the read capture below delays its strobe to match.
   sspi_sync u_miso_sync (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_async (i_miso),
      .o_sync  (miso_s)
   );

   assign half_done = (cnt == HALF_LAST);

   // Falling serial edge that carries a read data bit: the sixteen after the direction bit
   assign fall_rd = (state == S_SHIFT) && half_done && o_sck && !is_write
                    && (bit_idx > 5'(sspi_pkg::ADDR_W));

   // Sequencer: lead, shift, tail and gap phases
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state   <= S_IDLE;
         cnt     <= '0;
         bit_idx <= '0;
         o_ss_n  <= 1'b1;
      end else begin
         case (state)
            S_IDLE: begin
               cnt <= '0;
               if (i_req_valid) begin
                  o_ss_n <= 1'b0;
                  state  <= S_LEAD;
               end
            end
            S_LEAD: begin
               // Full serial period with clock low before the first rise
               if (cnt == LEAD_LAST) begin
                  cnt     <= '0;
                  bit_idx <= '0;
                  state   <= S_SHIFT;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            S_SHIFT: begin
               // Two-cycle half periods; a bit is finished at its falling edge,
               // and the last falling edge hands over to the lead-out
               if (half_done) begin
                  cnt <= '0;
                  if (o_sck) begin
                     if (bit_idx == LAST_BIT) begin
                        state <= S_TAIL;
                     end
                     bit_idx <= bit_idx + 1'b1;
                  end
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            S_TAIL: begin
               if (cnt == TAIL_LAST) begin
                  cnt    <= '0;
                  o_ss_n <= 1'b1;
                  state  <= S_GAP;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            S_GAP: begin
               if (cnt == GAP_LAST) begin
                  cnt   <= '0;
                  state <= S_IDLE;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            default: begin
               state  <= S_IDLE;
               o_ss_n <= 1'b1;
            end
         endcase
      end
   end

   // Serial clock divider: half period of whole system cycles keeps it under the limit.
   // The clock rests low outside the shift phase, so the slave never sees a stray edge
   // while deselected or during the lead-in and lead-out.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_sck <= 1'b0;
      end else if (state == S_SHIFT && half_done) begin
         o_sck <= ~o_sck;
      end else if (state != S_SHIFT) begin
         o_sck <= 1'b0;
      end
   end

   // Frame shift register: address, direction, data, all MSB first. The first bit is
   // put out together with select, one and a half periods before the first rising edge; each
   // later bit changes on a falling edge, half a period before the slave samples it.
   // For a read the data field is still i_req.wdata, so mosi carries it while the slave answers.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         shreg    <= '0;
         is_write <= 1'b0;
         o_mosi   <= 1'b0;
      end else if (state == S_IDLE && i_req_valid) begin
         // Direction bit follows the nine address bits
         shreg    <= {i_req.addr, i_req.write, i_req.wdata};
         is_write <= i_req.write;
         o_mosi   <= i_req.addr[sspi_pkg::ADDR_W-1];
      end else if (state == S_SHIFT && half_done && o_sck) begin
         // Falling edge: present the next bit
         shreg  <= {shreg[SR_W-2:0], 1'b0};
         o_mosi <= shreg[SR_W-2];
      end else if (state == S_TAIL || state == S_GAP) begin
         o_mosi <= 1'b0;
      end
   end

   // Read strobe pipeline: the falling-edge strobe is delayed by the synchroniser's two
   // stages, so the bit shifted in is the pin level at the falling edge itself. That
   // level settled half a period earlier and holds until the next rising edge.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cap_pipe <= 2'h0;
      end else begin
         cap_pipe <= {cap_pipe[0], fall_rd};
      end
   end

   // Read capture: sixteen falling-edge samples after the direction bit, MSB first
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rd_shift <= sspi_pkg::RDATA_RESET;
      end else if (state == S_LEAD) begin
         rd_shift <= sspi_pkg::RDATA_RESET;
      end else if (cap_pipe[1]) begin
         rd_shift <= {rd_shift[sspi_pkg::DATA_W-2:0], miso_s};
      end
   end

   // Answer pulse and ready level. Done rises on the edge that deselects the slave, so
   // rdata is complete by then: the last read bit is shifted in two cycles after the
   // last falling edge, while the lead-out still has two cycles to run.
   // Ready is informational and lags by one cycle; valid alone starts an access.
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rsp       <= '{done: 1'b0, was_write: 1'b0, rdata: sspi_pkg::RDATA_RESET};
         o_req_ready <= 1'b0;
      end else begin
         o_req_ready    <= (state == S_IDLE) && !i_req_valid;
         o_rsp.done     <= (state == S_TAIL) && (cnt == TAIL_LAST);
         if ((state == S_TAIL) && (cnt == TAIL_LAST)) begin
            o_rsp.was_write <= is_write;
            o_rsp.rdata     <= is_write ? o_rsp.rdata : rd_shift;
         end
      end
   end
endmodule : sspi_master

/* src/sspi_pkg.sv */
// Package for the serial register port master: constants, command and status structs.
// Assumes a 25 MHz system clock; the serial clock is derived from it by a divider.
package sspi_pkg;
   // System clock and serial timing
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned SCK_MIN_PERIOD_NS = 100;
   // Half period in system cycles, rounded up so the serial clock never exceeds its limit
   localparam int unsigned SCK_HALF_CYC    =
      (SCK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   localparam int unsigned SCK_PERIOD_CYC  = 2 * SCK_HALF_CYC;
   // Select-to-first-rise, last-fall-to-deselect, and gap between accesses in serial periods
   localparam int unsigned LEAD_PERIODS    = 1;
   localparam int unsigned TAIL_PERIODS    = 1;
   localparam int unsigned GAP_PERIODS     = 2;
   // Frame layout
   localparam int unsigned ADDR_W          = 9;
   localparam int unsigned DATA_W          = 16;
   localparam int unsigned FRAME_BITS      = ADDR_W + 1 + DATA_W;
   localparam logic        DIR_WRITE       = 1'b1;
   localparam logic        DIR_READ        = 1'b0;
   localparam logic [15:0] RDATA_RESET     = 16'h0000;

   // Request from the user side
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } sspi_req_t;

   // Answer to the user side
   typedef struct packed {
      logic              done;
      logic              was_write;
      logic [DATA_W-1:0] rdata;
   } sspi_rsp_t;
endpackage : sspi_pkg

/* src/sspi_sync.sv */
// Two-stage synchroniser for a pin level.
// Assumes the input is asynchronous to i_clk; only the second stage is read.
module sspi_sync (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset,
   // Level in and out
   input  wire logic i_async,
   output logic      o_sync
);
   timeunit 1ns;
   timeprecision 100ps;
   logic meta;

   // Two flip-flops in series
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta   <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule : sspi_sync

/* verification/sspi_master_chk.sv */
// Pin timing checker for the serial register port master.
// Bound to sspi_master; sees its ports only, sampled on the system clock.
module sspi_master_chk (
   // All top ports
   input wire logic                i_clk, i_reset, i_req_valid, o_req_ready,
   input wire sspi_pkg::sspi_req_t i_req,
   input wire sspi_pkg::sspi_rsp_t o_rsp,
   input wire logic                o_sck, o_ss_n, o_mosi, i_miso
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   logic [4:0] rises;
   // Counts serial clock rises inside one frame
   always_ff @(posedge i_clk) begin
      if (i_reset || o_ss_n) rises <= 5'h00;
      else if ($rose(o_sck)) rises <= rises + 5'h01;
   end
   a_sck_idle_low: assert property (o_ss_n |-> !o_sck)
      else $error("sck moves while deselected");
   a_lead_one_period: assert property ($fell(o_ss_n) |-> !o_sck [*4])
      else $error("first rise too early");
   a_mosi_on_fall: assert property (!o_ss_n && $changed(o_mosi) |->
      $fell(o_sck) || $fell(o_ss_n)) else $error("mosi changed off a falling edge");
   a_tail_one_period: assert property ($fell(o_sck) |-> !o_ss_n [*4])
      else $error("deselect too early");
   a_gap_two_periods: assert property ($rose(o_ss_n) |-> o_ss_n [*8])
      else $error("gap between accesses too short");
   a_frame_bit_count: assert property ($rose(o_ss_n) |-> rises == 5'h1A)
      else $error("frame length wrong");
   a_done_at_release: assert property (o_rsp.done |-> $rose(o_ss_n))
      else $error("done apart from deselect");
   a_sck_rate: assert property ($rose(o_sck) |-> ##1 o_sck ##1 !o_sck ##1 !o_sck)
      else $error("serial clock too fast");
   c_write: cover property (o_rsp.done && o_rsp.was_write);
   c_read: cover property (o_rsp.done && !o_rsp.was_write);
   c_burst: cover property ($rose(o_ss_n) ##[8:16] $fell(o_ss_n));
endmodule : sspi_master_chk

bind sspi_master sspi_master_chk chk (.i_clk, .i_reset, .i_req_valid, .o_req_ready, .i_req,
   .o_rsp, .o_sck, .o_ss_n, .o_mosi, .i_miso);

/* verification/sspi_master_test.sv */
// Self-checking bench for the serial register port master.
// A behavioural sensor port answers on the pins; the checker is bound in.
module sspi_master_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic                i_clk = 1'b0, i_reset = 1'b1, i_req_valid = 1'b0, slow = 1'b0;
   sspi_pkg::sspi_req_t i_req = '0;
   sspi_pkg::sspi_rsp_t o_rsp;
   logic                o_req_ready, o_sck, o_ss_n, o_mosi, i_miso;
   int                  error_cnt = 0, check_count = 0;
   // 25 MHz system clock
   always #20 i_clk = ~i_clk;
   sspi_master dut (.i_clk, .i_reset, .i_req_valid, .i_req, .o_req_ready, .o_rsp,
      .o_sck, .o_ss_n, .o_mosi, .i_miso);
   sspi_slave_model m (.i_sck(o_sck), .i_ss_n(o_ss_n), .i_mosi(o_mosi), .i_slow(slow),
      .o_miso(i_miso));
   // Compare and count
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Counts and verdict
   task summarize;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   // One access, valid held until done
   task xfer(input logic w, input logic [8:0] a, input logic [15:0] d);
      int k;
      k = 0;
      i_req_valid = 1'b1;
      i_req = '{w, a, d};
      do begin
         @(posedge i_clk);
         #1;
         k++;
      end while (o_rsp.done !== 1'b1 && k < 300);
      if (k >= 300) error_cnt++;
      if (k >= 300) summarize();
      i_req_valid = 1'b0;
      chk({15'h0000, o_rsp.was_write}, {15'h0000, w});
      chk({15'h0000, o_req_ready}, 16'h0000);
      @(posedge i_clk);
      #1;
   endtask : xfer
   // Pins idle under reset
   task t_reset;
      repeat (6) @(posedge i_clk);
      #1;
      chk({13'h0000, o_ss_n, o_sck, o_rsp.done}, 16'h0004);
      i_reset = 1'b0;
      @(posedge i_clk);
      #1;
      chk({15'h0000, o_req_ready}, 16'h0001);
      $display("t_reset done");
   endtask : t_reset
   // Boundary addresses written and seen in the port, the top one read back
   task t_write_read;
      xfer(1'b1, 9'h1FF, 16'hA5C3);
      chk(m.mem[9'h1FF], 16'hA5C3);
      xfer(1'b1, 9'h000, 16'h8001);
      chk(m.mem[9'h000], 16'h8001);
      xfer(1'b0, 9'h1FF, 16'h0000);
      chk(o_rsp.rdata, 16'hA5C3);
      $display("t_write_read done");
   endtask : t_write_read
   // Back-to-back writes, then reads in reverse order
   task t_burst;
      for (int i = 0; i < 4; i++) xfer(1'b1, 9'(i * 85), 16'(16'h1234 << i));
      for (int i = 3; i >= 0; i--) begin
         xfer(1'b0, 9'(i * 85), 16'h0000);
         chk(o_rsp.rdata, 16'(16'h1234 << i));
      end
      $display("t_burst done");
   endtask : t_burst
   // Read data arriving late in the serial cycle
   task t_slow;
      slow = 1'b1;
      xfer(1'b0, 9'h000, 16'h0000);
      chk(o_rsp.rdata, 16'h1234);
      slow = 1'b0;
      $display("t_slow done");
   endtask : t_slow
   // Main sequence
   initial begin
      t_reset();
      t_write_read();
      t_burst();
      t_slow();
      summarize();
   end
endmodule : sspi_master_test

/* verification/sspi_slave_model.sv */
// Behavioural sensor register port: 512 words of 16 bits behind the serial pins.
// Runs on the serial clock and select only; i_slow makes read data arrive late in the cycle.
module sspi_slave_model (
   input wire logic i_sck, i_ss_n, i_mosi, i_slow,
   output logic     o_miso
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [512];
   logic [25:0] sh;
   logic [15:0] rd;
   logic        rdg;
   int          n;
   initial o_miso = 1'b0;
   // Shift in on rising sck; a released miso shows the inverse of its last value
   always @(posedge i_sck or posedge i_ss_n) begin
      if (i_ss_n) begin
         n = 0;
         rdg = 1'b0;
         o_miso <= ~o_miso;
      end else begin
         sh = {sh[24:0], i_mosi};
         n++;
         if (n == 26 && sh[16]) mem[sh[25:17]] = sh[15:0];
         if (rdg) o_miso <= #(i_slow ? 30 : 2) rd[15];
         else o_miso <= ~o_miso;
         if (rdg) rd = rd << 1;
         if (n == 10 && !sh[0]) rdg = 1'b1;
         if (n == 10) rd = mem[sh[9:1]];
      end
   end
endmodule : sspi_slave_model
